/* File: inc/seq_pkg.sv */
// Shared types and constants of the sample sequencer.
package seq_pkg;
    localparam int NSEQ       = 4;
    localparam int MAXSTEP    = 8;
    localparam int DW         = 12;
    localparam int PTR_W      = 3;
    localparam int CNT_W      = 4;
    localparam logic [CNT_W-1:0] DEPTH0 = 4'h8;
    localparam logic [CNT_W-1:0] DEPTH1 = 4'h4;
    localparam logic [CNT_W-1:0] DEPTH2 = 4'h4;
    localparam logic [CNT_W-1:0] DEPTH3 = 4'h1;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // One programmed conversion step.
    typedef struct packed {
        logic       step_temp_sensor_sel;
        logic       step_irq_en;
        logic       step_last_mark;
        logic       step_diff_sel;
        logic [4:0] step_channel_sel;
        logic       step_comparator_en;
        logic [2:0] step_comparator_sel;
    } step_cfg_t;

    localparam step_cfg_t STEP_RST = '0;

    // A finished conversion with its routing tag.
    typedef struct packed {
        logic [1:0]    seq;
        logic          irq;
        logic          cmp_en;
        logic [2:0]    cmp_sel;
        logic [DW-1:0] data;
    } result_t;

    function automatic logic [CNT_W-1:0] depth_of(input logic [1:0] s);
        logic [CNT_W-1:0] d;
        d = DEPTH3;
        case (s)
            2'h0: d = DEPTH0;
            2'h1: d = DEPTH1;
            2'h2: d = DEPTH2;
            default: d = DEPTH3;
        endcase
        return d;
    endfunction : depth_of
endpackage : seq_pkg

/* File: hw/adc_sample_sequencer.sv */
// Four-sequencer conversion scheduler with per-sequencer sample FIFOs.
// Operation
// R1: A FIFO read returns only samples held now, maybe fewer than a full run.
// R2: A disabled sequencer ignores its trigger and captures nothing.
// R3: An enabled sequencer starts its run on every detected trigger; the code merges triggers arriving while its run is still pending into one run.
// R4: A trigger while unread samples remain sets that sequencer's overflow flag.
// R5: Overflow flag is sticky until cleared and has no other effect.
// R6: Reading an empty FIFO sets that sequencer's underflow flag.
// R7: Underflow flag is sticky until cleared and has no other effect.
// R8: Each step selects one of 24 analog inputs.
// R9: Each step has a differential versus single-ended select bit.
// R10: Each step may pick the temperature sensor instead of a channel.
// R11: The run stops after the step carrying the last mark.
// R12: A step with interrupt enable raises the interrupt on completion.
// R13: A result sent to an enabled comparator bypasses the FIFO.
// R14: Steps run in ascending order within 8, 4, 4 and 1 slots.
// R15: Software gives differential steps an adjacent pair number.
// R16: Software never mixes differential mode with the temperature sensor.
// R17: Step configuration is read when that step executes.
// R18: Software disables a sequencer before changing its configuration.
// R19: FIFOs hold at most 8, 4, 4 and 1 samples.
// R20: Pending sequencers are served lowest priority number first.
// R21: FIFOs return samples oldest first, one per read.
// R22: Each sequencer keeps a readable, clearable raw interrupt status bit.
`timescale 1ns/1ps
module adc_sample_sequencer (
    input  wire logic                    mclk,          // 10 MHz clock
    input  wire logic                    rstn,          // async reset, low
    input  wire logic [3:0]              seq_enable,    // per-sequencer enable
    input  wire logic [3:0]              seq_trigger,   // trigger pulses
    input  wire logic [7:0]              seq_priority,  // 2 bits each
    input  wire logic                    cfg_we,        // step write strobe
    input  wire logic [1:0]              cfg_seq,       // step write sequencer
    input  wire logic [2:0]              cfg_step,      // step write index
    input  wire seq_pkg::step_cfg_t      cfg_data,      // step write data
    output logic                         conv_req_valid, // conversion request
    input  wire logic                    conv_req_ready, // converter accepts
    output logic [4:0]                   conv_channel,  // input or pair
    output logic                         conv_diff,     // differential
    output logic                         conv_temp,     // temperature sensor
    input  wire logic                    conv_res_valid, // result ready
    output logic                         conv_res_ready, // result taken
    input  wire logic [seq_pkg::DW-1:0]  conv_res_data, // result value
    output logic                         cmp_valid,     // comparator pulse
    output logic [2:0]                   cmp_sel,       // comparator index
    output logic [seq_pkg::DW-1:0]       cmp_data,      // comparator sample
    input  wire logic                    rd_req,        // FIFO read pulse
    input  wire logic [1:0]              rd_seq,        // FIFO to read
    output logic                         rd_valid,      // read data valid
    output logic [seq_pkg::DW-1:0]       rd_data,       // read sample
    output logic [15:0]                  fifo_count,    // 4 bits each
    output logic [3:0]                   ovf_flag,      // overflow sticky
    input  wire logic [3:0]              ovf_clr,       // overflow clear
    output logic [3:0]                   unf_flag,      // underflow sticky
    input  wire logic [3:0]              unf_clr,       // underflow clear
    output logic [3:0]                   irq_raw,       // raw interrupt status
    input  wire logic [3:0]              irq_clr        // interrupt clear
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_r;
    logic rst_n;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // ************************************************************
    // Step configuration store
    // ************************************************************
    seq_pkg::step_cfg_t cfg_mem [seq_pkg::NSEQ][seq_pkg::MAXSTEP];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < seq_pkg::NSEQ; s++) begin
                for (int t = 0; t < seq_pkg::MAXSTEP; t++) begin
                    cfg_mem[s][t] <= seq_pkg::STEP_RST;
                end
            end
        end else if (cfg_we) begin
            cfg_mem[cfg_seq][cfg_step] <= cfg_data;
        end
    end

    // ************************************************************
    // Scheduler
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_ISSUE = 3'h2,
        ST_WAIT  = 3'h4
    } state_t;

    function automatic logic [2:0] pick_seq(input logic [3:0] pend,
                                            input logic [7:0] prio);
        logic [2:0] r;
        r = 3'h0;
        for (int p = 3; p >= 0; p--) begin
            for (int s = 0; s < 4; s++) begin
                if (pend[s] && prio[2*s +: 2] == 2'(p)) begin
                    r = {1'b1, 2'(s)};
                end
            end
        end
        return r;
    endfunction : pick_seq

    state_t              state_r;
    state_t              state_nxt;
    logic [3:0]          pend_r;
    logic [1:0]          cur_seq_r;
    logic [1:0]          cur_seq_nxt;
    logic [2:0]          cur_step_r;
    logic [2:0]          cur_step_nxt;
    seq_pkg::step_cfg_t  cur_cfg_r;
    logic [3:0]          nonempty;
    logic [3:0]          ovf_r;
    logic [3:0]          unf_r;
    logic [3:0]          irq_r;
    logic                buf_in_ready;

    wire logic [2:0] pick      = pick_seq(pend_r, seq_priority);
    wire logic       start     = (state_r == ST_IDLE) && pick[2];
    wire logic       res_take  = (state_r == ST_WAIT) && conv_res_valid && buf_in_ready;
    wire logic       step_last = cur_cfg_r.step_last_mark ||
                                 ({1'b0, cur_step_r} == seq_pkg::depth_of(cur_seq_r) - 4'h1);
    wire logic [3:0] start_mask = start ? 4'(1 << pick[1:0]) : 4'h0;
    wire logic [3:0] trig_ok    = seq_trigger & seq_enable; // R2 R3

    always_comb begin
        state_nxt    = state_r;
        cur_seq_nxt  = cur_seq_r;
        cur_step_nxt = cur_step_r;
        unique case (state_r)
            ST_IDLE: begin
                if (pick[2]) begin // R20
                    state_nxt    = ST_ISSUE;
                    cur_seq_nxt  = pick[1:0];
                    cur_step_nxt = 3'h0;
                end
            end
            ST_ISSUE: begin
                if (conv_req_ready) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (res_take) begin
                    if (step_last) begin // R11
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt    = ST_ISSUE;
                        cur_step_nxt = cur_step_r + 3'h1; // R14
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_IDLE;
            pend_r     <= 4'h0;
            cur_seq_r  <= 2'h0;
            cur_step_r <= 3'h0;
            cur_cfg_r  <= seq_pkg::STEP_RST;
        end else begin
            state_r    <= state_nxt;
            pend_r     <= (pend_r & ~start_mask) | trig_ok; // R3
            cur_seq_r  <= cur_seq_nxt;
            cur_step_r <= cur_step_nxt;
            cur_cfg_r  <= cfg_mem[cur_seq_nxt][cur_step_nxt]; // R17
        end
    end

    assign conv_req_valid = (state_r == ST_ISSUE);
    assign conv_channel   = cur_cfg_r.step_channel_sel; // R8 R15
    assign conv_diff      = cur_cfg_r.step_diff_sel; // R9 R16
    assign conv_temp      = cur_cfg_r.step_temp_sensor_sel; // R10
    assign conv_res_ready = (state_r == ST_WAIT) && buf_in_ready;

    // ************************************************************
    // Two-entry result buffer
    // ************************************************************
    seq_pkg::result_t buf_q [2];
    logic [1:0]       buf_cnt_r;
    logic             buf_pop;
    wire seq_pkg::result_t buf_in = '{seq: cur_seq_r, irq: cur_cfg_r.step_irq_en,
        cmp_en: cur_cfg_r.step_comparator_en, cmp_sel: cur_cfg_r.step_comparator_sel,
        data: conv_res_data};
    wire seq_pkg::result_t buf_out = buf_q[0];
    wire logic buf_out_valid = (buf_cnt_r != 2'h0);
    assign buf_in_ready = (buf_cnt_r != seq_pkg::BUF_DEPTH);
    wire logic [3:0] cnt_room;
    assign buf_pop = buf_out_valid && (buf_out.cmp_en || cnt_room[buf_out.seq]);
    wire logic [1:0] wr_slot = buf_cnt_r - (buf_pop ? 2'h1 : 2'h0);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            buf_cnt_r <= 2'h0;
            buf_q[0]  <= '0;
            buf_q[1]  <= '0;
        end else begin
            if (buf_pop) begin
                buf_q[0] <= buf_q[1];
            end
            if (res_take) begin
                buf_q[wr_slot[0]] <= buf_in;
            end
            buf_cnt_r <= buf_cnt_r + (res_take ? 2'h1 : 2'h0) - (buf_pop ? 2'h1 : 2'h0);
        end
    end

    // ************************************************************
    // Comparator delivery
    // ************************************************************
    wire logic to_cmp = buf_pop && buf_out.cmp_en;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_valid <= 1'b0;
            cmp_sel   <= 3'h0;
            cmp_data  <= '0;
        end else begin
            cmp_valid <= to_cmp; // R13
            if (to_cmp) begin
                cmp_sel  <= buf_out.cmp_sel;
                cmp_data <= buf_out.data;
            end
        end
    end

    // ************************************************************
    // Per-sequencer FIFOs and flags
    // ************************************************************
    logic [seq_pkg::DW-1:0] rd_word [seq_pkg::NSEQ];
    logic [3:0]             wr_mask;
    logic [3:0]             rd_mask;
    for (genvar s = 0; s < seq_pkg::NSEQ; s++) begin : g_seq
        logic [seq_pkg::DW-1:0]    mem [seq_pkg::MAXSTEP];
        logic [seq_pkg::PTR_W-1:0] wptr_r;
        logic [seq_pkg::PTR_W-1:0] rptr_r;
        logic [seq_pkg::CNT_W-1:0] cnt_r;
        wire logic [seq_pkg::CNT_W-1:0] depth = seq_pkg::depth_of(2'(s));
        wire logic [seq_pkg::PTR_W-1:0] ptr_max = 3'(depth - 4'h1);
        wire logic rd_hit = rd_req && (rd_seq == 2'(s));
        wire logic do_rd  = rd_hit && (cnt_r != 4'h0); // R1
        wire logic do_wr  = buf_pop && !buf_out.cmp_en && (buf_out.seq == 2'(s)); // R13
        assign cnt_room[s] = (cnt_r != depth); // R19
        assign nonempty[s] = (cnt_r != 4'h0);
        assign wr_mask[s]  = do_wr;
        assign rd_mask[s]  = do_rd;
        assign rd_word[s]  = mem[rptr_r];
        assign fifo_count[4*s +: 4] = cnt_r;
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                wptr_r <= 3'h0;
                rptr_r <= 3'h0;
                cnt_r  <= 4'h0;
                ovf_r[s] <= 1'b0;
                unf_r[s] <= 1'b0;
                irq_r[s] <= 1'b0;
                for (int i = 0; i < seq_pkg::MAXSTEP; i++) begin
                    mem[i] <= '0;
                end
            end else begin
                if (do_wr) begin
                    mem[wptr_r] <= buf_out.data;
                    wptr_r <= (wptr_r == ptr_max) ? 3'h0 : wptr_r + 3'h1;
                end
                if (do_rd) begin
                    rptr_r <= (rptr_r == ptr_max) ? 3'h0 : rptr_r + 3'h1; // R21
                end
                cnt_r <= cnt_r + (do_wr ? 4'h1 : 4'h0) - (do_rd ? 4'h1 : 4'h0);
                ovf_r[s] <= (ovf_r[s] && !ovf_clr[s]) || (trig_ok[s] && nonempty[s]); // R4 R5
                unf_r[s] <= (unf_r[s] && !unf_clr[s]) || (rd_hit && !nonempty[s]); // R6 R7
                irq_r[s] <= (irq_r[s] && !irq_clr[s]) ||
                            (buf_pop && buf_out.irq && buf_out.seq == 2'(s)); // R12 R22
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_valid <= (rd_mask != 4'h0);
            if (rd_mask != 4'h0) begin
                rd_data <= rd_word[rd_seq];
            end
        end
    end

    assign ovf_flag = ovf_r;
    assign unf_flag = unf_r;
    assign irq_raw  = irq_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_ignore_disabled;
        (seq_trigger & ~seq_enable & ~pend_r) != 4'h0
            |=> (pend_r & $past(seq_trigger & ~seq_enable & ~pend_r)) == 4'h0;
    endproperty
    a_ignore_disabled: assert property (p_ignore_disabled) else $error("disabled trigger taken"); // R2
    property p_trig_pend;
        trig_ok != 4'h0 |=> (pend_r & $past(trig_ok)) == $past(trig_ok);
    endproperty
    a_trig_pend: assert property (p_trig_pend) else $error("trigger not pending"); // R3
    property p_ovf_set;
        (trig_ok & nonempty) != 4'h0 |=> (ovf_r & $past(trig_ok & nonempty)) != 4'h0;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged"); // R4
    property p_ovf_hold;
        (ovf_r & ~ovf_clr) != 4'h0 |=> ($past(ovf_r & ~ovf_clr) & ~ovf_r) == 4'h0;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost"); // R5
    property p_unf_set;
        rd_req && !nonempty[rd_seq] |=> unf_r[$past(rd_seq)];
    endproperty
    a_unf_set: assert property (p_unf_set) else $error("underflow not flagged"); // R6
    property p_unf_hold;
        (unf_r & ~unf_clr) != 4'h0 |=> ($past(unf_r & ~unf_clr) & ~unf_r) == 4'h0;
    endproperty
    a_unf_hold: assert property (p_unf_hold) else $error("underflow lost"); // R7
    property p_cmp_bypass;
        buf_pop && buf_out.cmp_en |-> wr_mask == 4'h0 ##1 cmp_valid;
    endproperty
    a_cmp_bypass: assert property (p_cmp_bypass) else $error("comparator result in fifo"); // R13
    property p_irq_set;
        buf_pop && buf_out.irq |=> irq_r[$past(buf_out.seq)];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("step interrupt missing"); // R12
    property p_step_order;
        res_take && !step_last |=> state_r == ST_ISSUE && cur_step_r == $past(cur_step_r) + 3'h1;
    endproperty
    a_step_order: assert property (p_step_order) else $error("step order broken"); // R14
    property p_last_stop;
        res_take && step_last |=> state_r == ST_IDLE;
    endproperty
    a_last_stop: assert property (p_last_stop) else $error("run did not stop"); // R11
    property p_prio;
        start |=> cur_seq_r == $past(pick[1:0]) && cur_step_r == 3'h0;
    endproperty
    a_prio: assert property (p_prio) else $error("wrong sequencer started"); // R20
    property p_read;
        rd_req && nonempty[rd_seq] |=> rd_valid && rd_data == $past(rd_word[rd_seq]);
    endproperty
    a_read: assert property (p_read) else $error("fifo read failed"); // R1
    property p_depth;
        fifo_count[3:0] <= seq_pkg::DEPTH0 && fifo_count[7:4] <= seq_pkg::DEPTH1 &&
        fifo_count[11:8] <= seq_pkg::DEPTH2 && fifo_count[15:12] <= seq_pkg::DEPTH3;
    endproperty
    a_depth: assert property (p_depth) else $error("fifo beyond depth"); // R19

    c_run_done: cover property (res_take && step_last);
    c_overflow: cover property ($rose(ovf_r[0]));
    c_cmp: cover property (to_cmp);
    c_buf_full: cover property (buf_cnt_r == seq_pkg::BUF_DEPTH);
endmodule : adc_sample_sequencer

/* File: sim/tb_top.sv */
// Self-checking testbench of the sample sequencer against a queue model.
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        int                 s;
        seq_pkg::step_cfg_t c;
    } run_step_t;
    logic                   mclk, rstn, cfg_we, rd_req, rd_valid, cmp_valid;
    logic                   conv_req_valid, conv_req_ready, conv_diff, conv_temp;
    logic                   conv_res_valid, conv_res_ready;
    logic [3:0]             seq_enable, seq_trigger, ovf_flag, ovf_clr, unf_flag, unf_clr;
    logic [3:0]             irq_raw, irq_clr, ovf_m, unf_m, irq_m;
    logic [7:0]             seq_priority;
    logic [1:0]             cfg_seq, rd_seq;
    logic [2:0]             cfg_step, cmp_sel;
    logic [4:0]             conv_channel;
    logic [15:0]            fifo_count;
    logic [seq_pkg::DW-1:0] conv_res_data, cmp_data, rd_data;
    seq_pkg::step_cfg_t     cfg_data;
    seq_pkg::step_cfg_t     cfg_m [4][8];
    run_step_t              exp_q [$];
    int                     fifo_q [4][$];
    int                     cmp_q [$];
    int                     dep [4];
    int                     prio [4];
    int                     err_total, num_checks, lag;
    bit                     busy;

    adc_sample_sequencer uut (
        .mclk(mclk), .rstn(rstn), .seq_enable(seq_enable), .seq_trigger(seq_trigger),
        .seq_priority(seq_priority), .cfg_we(cfg_we), .cfg_seq(cfg_seq),
        .cfg_step(cfg_step), .cfg_data(cfg_data), .conv_req_valid(conv_req_valid),
        .conv_req_ready(conv_req_ready), .conv_channel(conv_channel), .conv_diff(conv_diff),
        .conv_temp(conv_temp), .conv_res_valid(conv_res_valid),
        .conv_res_ready(conv_res_ready), .conv_res_data(conv_res_data),
        .cmp_valid(cmp_valid), .cmp_sel(cmp_sel), .cmp_data(cmp_data), .rd_req(rd_req),
        .rd_seq(rd_seq), .rd_valid(rd_valid), .rd_data(rd_data), .fifo_count(fifo_count),
        .ovf_flag(ovf_flag), .ovf_clr(ovf_clr), .unf_flag(unf_flag), .unf_clr(unf_clr),
        .irq_raw(irq_raw), .irq_clr(irq_clr)
    );

    // ************************************************************
    // Driver and comparison tasks.
    // ************************************************************
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    function automatic seq_pkg::step_cfg_t mk(input int ch, input bit last, input bit cmp);
        seq_pkg::step_cfg_t c;
        c = seq_pkg::STEP_RST;
        c.step_channel_sel = 5'(ch);
        c.step_last_mark = last;
        c.step_comparator_en = cmp;
        c.step_comparator_sel = 3'($urandom_range(0, 7));
        c.step_irq_en = 1'($urandom_range(0, 1));
        c.step_temp_sensor_sel = 1'($urandom_range(0, 1));
        c.step_diff_sel = ch < 12 && !c.step_temp_sensor_sel && $urandom_range(0, 1);
        return c;
    endfunction : mk

    task automatic setup(input int s, input int n, input bit cmp);
        seq_enable[s] = 1'b0;
        for (int k = 0; k < n; k++) begin
            tick();
            cfg_m[s][k] = mk($urandom_range(0, 23), k == n - 1 && n < dep[s], cmp);
            cfg_we = 1'b1;
            cfg_seq = 2'(s);
            cfg_step = 3'(k);
            cfg_data = cfg_m[s][k];
            tick();
            cfg_we = 1'b0;
        end
        seq_enable[s] = 1'b1;
    endtask : setup

    task automatic trig(input logic [3:0] m);
        tick();
        seq_trigger = m;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 4; s++) begin
                if (m[s] && seq_enable[s] && prio[s] == p) begin
                    if (fifo_q[s].size() > 0) ovf_m[s] = 1'b1;
                    for (int k = 0; k < dep[s]; k++) begin
                        exp_q.push_back('{s, cfg_m[s][k]});
                        if (cfg_m[s][k].step_last_mark) break;
                    end
                end
            end
        end
        tick();
        seq_trigger = 4'h0;
    endtask : trig

    task automatic rd(input int s);
        logic hit;
        tick();
        rd_req = 1'b1;
        rd_seq = 2'(s);
        tick();
        rd_req = 1'b0;
        hit = fifo_q[s].size() > 0;
        chk(16'(rd_valid), 16'(hit), "read valid");
        if (hit) chk(16'(rd_data), 16'(fifo_q[s].pop_front()), "read data");
        else unf_m[s] = 1'b1;
    endtask : rd

    task automatic flags();
        for (int i = 0; i < 3000 && (exp_q.size() > 0 || busy); i++) tick();
        repeat (8) tick();
        chk(16'(exp_q.size()), 16'h0000, "steps not run");
        for (int s = 0; s < 4; s++) begin
            chk(16'(fifo_count[4*s +: 4]), 16'(fifo_q[s].size()), "count");
        end
        chk({4'h0, ovf_flag, unf_flag, irq_raw}, {4'h0, ovf_m, unf_m, irq_m}, "flags");
    endtask : flags

    task automatic clr(input logic [3:0] o, input logic [3:0] u, input logic [3:0] i);
        tick();
        ovf_clr = o;
        unf_clr = u;
        irq_clr = i;
        ovf_m = ovf_m & ~o;
        unf_m = unf_m & ~u;
        irq_m = irq_m & ~i;
        tick();
        {ovf_clr, unf_clr, irq_clr} = 12'h000;
    endtask : clr

    task automatic drain();
        for (int s = 0; s < 4; s++) begin
            while (fifo_q[s].size() > 0) rd(s);
        end
    endtask : drain

    // ************************************************************
    // Converter side, clock and monitors.
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) conv_req_ready <= #1 1'($urandom_range(0, 1));

    // Handshakes are judged at the falling edge, where the design's outputs have settled.
    initial begin : conv_side
        run_step_t e;
        int        d;
        busy = 1'b0;
        conv_res_valid = 1'b0;
        conv_res_data = '0;
        forever begin
            @(negedge mclk);
            if (conv_req_valid === 1'b1 && conv_req_ready === 1'b1) begin
                busy = 1'b1;
                e = '{0, seq_pkg::STEP_RST};
                if (exp_q.size() > 0) e = exp_q.pop_front();
                else chk(16'h0000, 16'h0001, "extra conversion");
                chk(16'({conv_temp, conv_diff, conv_channel}), 16'({e.c.step_temp_sensor_sel,
                    e.c.step_diff_sel, e.c.step_channel_sel}), "request");
                @(posedge mclk);
                repeat (lag + $urandom_range(0, 2)) @(posedge mclk);
                #1;
                conv_res_valid = 1'b1;
                conv_res_data = 12'($urandom);
                d = 0;
                do @(negedge mclk); while (conv_res_ready !== 1'b1 && ++d < 3000);
                @(posedge mclk);
                if (e.c.step_comparator_en) cmp_q.push_back(e.c.step_comparator_sel * 4096
                    + int'(conv_res_data));
                else fifo_q[e.s].push_back(int'(conv_res_data));
                if (e.c.step_irq_en) irq_m[e.s] = 1'b1;
                #1;
                conv_res_valid = 1'b0;
                conv_res_data = ~conv_res_data;
                busy = 1'b0;
            end
        end
    end

    always @(negedge mclk) begin
        if (rstn === 1'b1 && cmp_valid === 1'b1) begin
            chk(16'(cmp_q.size() > 0), 16'h0001, "comparator pulse");
            if (cmp_q.size() > 0) chk({1'b0, cmp_sel, cmp_data}, 16'(cmp_q.pop_front()), "comparator");
        end
    end

    initial begin : watchdog
        repeat (40000) @(posedge mclk);
        err_total++;
        end_sim();
    end

    initial begin : main
        {rstn, cfg_we, rd_req} = 3'h0;
        {seq_enable, seq_trigger, ovf_clr, unf_clr, irq_clr} = 20'h00000;
        {ovf_m, unf_m, irq_m} = 12'h000;
        {cfg_seq, rd_seq, cfg_step} = 7'h00;
        cfg_data = seq_pkg::STEP_RST;
        err_total = 0;
        num_checks = 0;
        lag = 0;
        dep = '{int'(seq_pkg::DEPTH0), int'(seq_pkg::DEPTH1), int'(seq_pkg::DEPTH2),
            int'(seq_pkg::DEPTH3)};
        prio = '{2, 3, 1, 0};
        seq_priority = 8'h1E;
        void'($urandom(32'hD8DED870));
        repeat (16) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge mclk);
        // A disabled sequencer ignores its trigger.
        setup(0, 8, 1'b0);
        tick();
        seq_enable[0] = 1'b0;
        trig(4'h1);
        flags();
        seq_enable[0] = 1'b1;
        // Partial read while a slow run is still in progress.
        lag = 30;
        trig(4'h1);
        for (int i = 0; i < 500 && fifo_q[0].size() < 2; i++) tick();
        repeat (4) tick();
        chk(16'(fifo_count[3:0]), 16'h0002, "partial count");
        rd(0);
        rd(0);
        lag = 0;
        flags();
        repeat (7) rd(0);
        flags();
        clr(4'h0, 4'hF, 4'hF);
        flags();
        // Overflow is sticky and harmless until cleared.
        setup(1, 2, 1'b0);
        trig(4'h2);
        flags();
        trig(4'h2);
        flags();
        drain();
        trig(4'h2);
        flags();
        clr(4'h2, 4'h0, 4'h0);
        flags();
        trig(4'h2);
        flags();
        drain();
        // A full FIFO stalls the converter side without losing samples.
        setup(2, 4, 1'b0);
        trig(4'h4);
        flags();
        trig(4'h4);
        repeat (40) tick();
        chk(16'({fifo_count[11:8], conv_res_valid, conv_res_ready}), 16'h0012, "stall");
        drain();
        flags();
        clr(4'hF, 4'hF, 4'hF);
        // Random step programs on all sequencers triggered together.
        for (int r = 0; r < 4; r++) begin
            for (int s = 0; s < 4; s++) setup(s, $urandom_range(1, dep[s]), 1'($urandom_range(0, 1)));
            trig(4'hF);
            flags();
            drain();
            flags();
            clr(4'hF, 4'hF, 4'hF);
        end
        end_sim();
    end
endmodule : tb_top
